// >>> core/amw_pkg.sv
package amw_pkg;

	// task-file register selects on the three address lines
	localparam logic [2:0] TF_DATA = 3'h0;
	localparam logic [2:0] TF_ERR  = 3'h1; // error_flags on read, feature_select on write
	localparam logic [2:0] TF_CNT  = 3'h2;
	localparam logic [2:0] TF_LOW  = 3'h3;
	localparam logic [2:0] TF_MID  = 3'h4;
	localparam logic [2:0] TF_HIGH = 3'h5;
	localparam logic [2:0] TF_DEV  = 3'h6;
	localparam logic [2:0] TF_CMD  = 3'h7; // command_code on write, device_state on read

	// command codes
	localparam logic [7:0] CMD_WR_MULT     = 8'hc5;
	localparam logic [7:0] CMD_WR_MULT_EXT = 8'h39;

	// device_state bit positions
	localparam int ST_BSY = 7;
	localparam int ST_RDY = 6;
	localparam int ST_DF  = 5;
	localparam int ST_DSC = 4;
	localparam int ST_DRQ = 3;
	localparam int ST_ERR = 0;

	// error_flags bit positions
	localparam int ERR_IDN = 4;
	localparam int ERR_ABT = 2;

	// unit_and_head_select: address-mode bit
	localparam int DEV_LBA = 6;

	// reset values
	localparam logic [7:0]  DEV_RESET  = 8'ha0;
	localparam logic [15:0] CNT_RESET  = 16'h0001;
	localparam logic [15:0] LOW_RESET  = 16'h0001;
	localparam logic [15:0] ADDR_RESET = 16'h0000;

	// 512-byte sector in 16-bit words
	localparam int SECTOR_WORDS = 256;

	// default CHS geometry for address advance in CHS mode
	localparam logic [3:0] CHS_LAST_HEAD = 4'hf;
	localparam logic [7:0] CHS_SPT       = 8'h3f;

	typedef struct packed {
		logic        wr;    // write strobe, one cycle
		logic        rd;    // read strobe, one cycle
		logic [2:0]  sel;   // register select
		logic [15:0] wdata; // write data
	} amw_tf_req_t;

	typedef struct packed {
		logic [47:0] lba;  // sector address (packed chs when chs mode)
		logic [15:0] data; // payload word
		logic        last; // last word of the sector
	} amw_media_word_t;

endpackage

// >>> core/amw_sector_buffer.sv
`timescale 1ns/10ps
// one-sector staging buffer: fills from the host, then drains to the media side
module amw_sector_buffer (
	input  wire logic                      clk_i,         // system clock
	input  wire logic                      reset_n_i,     // async reset, active low
	input  wire logic                      push_i,        // host data word strobe
	input  wire logic [15:0]               word_i,        // host data word
	input  wire logic [47:0]               lba_i,         // address of the sector being staged
	output logic                           full_o,        // sector complete, draining
	output amw_pkg::amw_media_word_t       media_o,       // word toward media
	output logic                           media_valid_o, // media word valid
	input  wire logic                      media_ready_i  // media takes the word
);
	logic [15:0] mem_q [amw_pkg::SECTOR_WORDS];
	logic [8:0]  fill_q, fill_d;
	logic [7:0]  rd_q, rd_d;
	logic        drain_q, drain_d;

	// fill counter reaches a whole sector before draining starts; pushes during drain are dropped
	always_comb begin
		fill_d  = fill_q;
		rd_d    = rd_q;
		drain_d = drain_q;
		if (!drain_q && push_i) begin
			fill_d = fill_q + 9'h001;
			if (fill_q == 9'(amw_pkg::SECTOR_WORDS - 1)) begin
				drain_d = 1'b1;
			end
		end
		if (drain_q && media_ready_i) begin
			rd_d = rd_q + 8'h01;
			if (rd_q == 8'(amw_pkg::SECTOR_WORDS - 1)) begin
				drain_d = 1'b0;
				fill_d  = 9'h000;
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			fill_q  <= 9'h000;
			rd_q    <= 8'h00;
			drain_q <= 1'b0;
		end else begin
			fill_q  <= fill_d;
			rd_q    <= rd_d;
			drain_q <= drain_d;
		end
	end

	// storage has no reset; only written words are ever read
	always_ff @(posedge clk_i) begin
		if (!drain_q && push_i) begin
			mem_q[fill_q[7:0]] <= word_i;
		end
	end

	assign full_o        = drain_q;
	assign media_valid_o = drain_q;
	// one driver for the whole word, so the output struct never has split drivers
	assign media_o       = '{lba: lba_i, data: mem_q[rd_q], last: (rd_q == 8'(amw_pkg::SECTOR_WORDS - 1))};
endmodule

// >>> core/amw_write_multiple.sv
`timescale 1ns/10ps
// Overview of operation
// - command code c5h starts the 28-bit block-mode write with per-block interrupts.
// - command code 39h starts the 48-bit extended block-mode write.
// - behaves as single-sector write, but interrupts once per block, not per sector.
// - sector payload enters through the data port as 16-bit words from the host.
// - 28-bit command takes the 8-bit count; zero means 256 sectors.
// - extended count is previous byte high, current byte low; zero means 65,536.
// - with lba select set, address is head, high, mid, low bytes (28 bits).
// - with lba select clear, low is sector, mid/high cylinder, head field head.
// - after 28-bit command, count holds sectors not written; zero unless error.
// - after 28-bit command, address registers hold the last transferred sector.
// - extended address bytes map current/previous; on error report failing address.
// - received sectors are passed on to be recorded on the media.
// - an uncorrectable write failure stops the command at the failing sector.
module amw_write_multiple (
	input  wire logic                      clk_i,         // system clock, 100 MHz
	input  wire logic                      reset_n_i,     // async reset, active low
	input  amw_pkg::amw_tf_req_t           tf_i,          // task-file access from host
	output logic [15:0]                    rdata_o,       // task-file read data
	input  wire logic                      hob_i,         // read previous bytes of ext registers
	input  wire logic [7:0]                block_size_i,  // configured sectors per block
	output logic                           intrq_o,       // host interrupt, level
	output amw_pkg::amw_media_word_t       media_o,       // word toward media
	output logic                           media_valid_o, // media word valid
	input  wire logic                      media_ready_i, // media takes the word
	input  wire logic                      media_done_i,  // sector recorded, pulse
	input  wire logic                      media_fail_i   // sector failed, pulse
);
	typedef enum logic [1:0] {S_IDLE, S_XFER, S_FLUSH} amw_state_t;

	amw_state_t  state_q, state_d;
	// count and address task-file copies are two bytes deep: previous and current
	logic [15:0] cnt_q, cnt_d, low_q, low_d, mid_q, mid_d, high_q, high_d;
	logic [7:0]  dev_q, dev_d, err_q, err_d;
	logic        bsy_q, bsy_d, drq_q, drq_d, errb_q, errb_d;
	logic        intrq_q, intrq_d, ext_q, ext_d, chs_q, chs_d;
	logic [16:0] rem_q, rem_d;
	logic [7:0]  blk_q, blk_d;
	logic [47:0] addr_q, addr_d;
	logic [15:0] rdata_q, rdata_d;
	logic        buf_full;
	logic        push;
	logic        wr_tf;
	logic        int_set, int_clr;
	logic [7:0]  status;

	// next address: lba counts up; chs walks sector, then head, then cylinder
	function automatic logic [47:0] next_addr(input logic [47:0] a, input logic chs);
		logic [47:0] n;
		n = a + 48'h1;
		if (chs) begin
			n = a;
			if (a[7:0] == amw_pkg::CHS_SPT) begin
				n[7:0] = 8'h01;
				if (a[27:24] == amw_pkg::CHS_LAST_HEAD) begin
					n[27:24] = 4'h0;
					n[23:8]  = a[23:8] + 16'h0001;
				end else begin
					n[27:24] = a[27:24] + 4'h1;
				end
			end else begin
				n[7:0] = a[7:0] + 8'h01;
			end
		end
		return n;
	endfunction

	// hob selects which byte of a two-deep task-file register the host sees
	function automatic logic [7:0] pick_byte(input logic [15:0] r, input logic hob);
		return hob ? r[15:8] : r[7:0];
	endfunction

	// extended address lane as previous/current bytes; lane 0 low, 1 mid, 2 high
	function automatic logic [15:0] ext_lane(input logic [47:0] a, input logic [1:0] lane);
		logic [15:0] r;
		case (lane)
			2'h0:    r = {a[31:24], a[7:0]};
			2'h1:    r = {a[39:32], a[15:8]};
			default: r = {a[47:40], a[23:16]};
		endcase
		return r;
	endfunction

	// status byte: ready and seek complete stay set, fault never raised here
	always_comb begin
		status                 = 8'h00;
		status[amw_pkg::ST_BSY] = bsy_q;
		status[amw_pkg::ST_RDY] = 1'b1;
		status[amw_pkg::ST_DF]  = 1'b0;
		status[amw_pkg::ST_DSC] = 1'b1;
		status[amw_pkg::ST_DRQ] = drq_q;
		status[amw_pkg::ST_ERR] = errb_q;
	end

	// registers other than data are locked while busy, as the host must not touch them then
	assign wr_tf = tf_i.wr && !bsy_q;
	assign push  = tf_i.wr && (tf_i.sel == amw_pkg::TF_DATA) && (state_q == S_XFER) && drq_q;

	// read mux; data is registered so the bus sees a flop, one cycle after the strobe
	always_comb begin
		rdata_d = rdata_q;
		if (tf_i.rd) begin
			case (tf_i.sel)
				amw_pkg::TF_ERR:  rdata_d = {8'h00, err_q};
				amw_pkg::TF_CNT:  rdata_d = {8'h00, pick_byte(cnt_q, hob_i)};
				amw_pkg::TF_LOW:  rdata_d = {8'h00, pick_byte(low_q, hob_i)};
				amw_pkg::TF_MID:  rdata_d = {8'h00, pick_byte(mid_q, hob_i)};
				amw_pkg::TF_HIGH: rdata_d = {8'h00, pick_byte(high_q, hob_i)};
				amw_pkg::TF_DEV:  rdata_d = {8'h00, dev_q};
				amw_pkg::TF_CMD:  rdata_d = {8'h00, status};
				default:          rdata_d = 16'h0000;
			endcase
		end
	end

	// command interpreter and per-sector progress
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		low_d   = low_q;
		mid_d   = mid_q;
		high_d  = high_q;
		dev_d   = dev_q;
		err_d   = err_q;
		bsy_d   = bsy_q;
		drq_d   = drq_q;
		errb_d  = errb_q;
		ext_d   = ext_q;
		chs_d   = chs_q;
		rem_d   = rem_q;
		blk_d   = blk_q;
		addr_d  = addr_q;
		int_set = 1'b0;
		int_clr = (tf_i.rd && tf_i.sel == amw_pkg::TF_CMD) || (wr_tf && tf_i.sel == amw_pkg::TF_CMD);
		// count and address writes shift the current byte into the previous byte
		if (wr_tf && state_q == S_IDLE) begin
			case (tf_i.sel)
				amw_pkg::TF_CNT:  cnt_d  = {cnt_q[7:0], tf_i.wdata[7:0]};
				amw_pkg::TF_LOW:  low_d  = {low_q[7:0], tf_i.wdata[7:0]};
				amw_pkg::TF_MID:  mid_d  = {mid_q[7:0], tf_i.wdata[7:0]};
				amw_pkg::TF_HIGH: high_d = {high_q[7:0], tf_i.wdata[7:0]};
				amw_pkg::TF_DEV:  dev_d  = tf_i.wdata[7:0];
				default:          ;
			endcase
		end
		case (state_q)
			S_IDLE: begin
				if (wr_tf && tf_i.sel == amw_pkg::TF_CMD) begin
					// a command write restarts error reporting; the block counter starts afresh
					err_d  = 8'h00;
					errb_d = 1'b0;
					blk_d  = 8'h00;
					if ((tf_i.wdata[7:0] == amw_pkg::CMD_WR_MULT) && (block_size_i != 8'h00)) begin
						ext_d   = 1'b0;
						chs_d   = !dev_q[amw_pkg::DEV_LBA];
						rem_d   = (cnt_q[7:0] == 8'h00) ? 17'h00100 : {9'h000, cnt_q[7:0]};
						addr_d  = {20'h00000, dev_q[3:0], high_q[7:0], mid_q[7:0], low_q[7:0]};
						drq_d   = 1'b1;
						state_d = S_XFER;
					end else if ((tf_i.wdata[7:0] == amw_pkg::CMD_WR_MULT_EXT) && (block_size_i != 8'h00)) begin
						ext_d   = 1'b1;
						chs_d   = 1'b0;
						rem_d   = (cnt_q == 16'h0000) ? 17'h10000 : {1'b0, cnt_q};
						addr_d  = {high_q[15:8], mid_q[15:8], low_q[15:8], high_q[7:0], mid_q[7:0], low_q[7:0]};
						drq_d   = 1'b1;
						state_d = S_XFER;
					end else begin
						// unknown code or no block size configured: abort at once
						err_d[amw_pkg::ERR_ABT] = 1'b1;
						errb_d  = 1'b1;
						int_set = 1'b1;
					end
				end
			end
			S_XFER: begin
				// a whole sector is staged; hold the host off while it is recorded
				if (buf_full) begin
					drq_d   = 1'b0;
					bsy_d   = 1'b1;
					state_d = S_FLUSH;
				end
			end
			S_FLUSH: begin
				if (media_fail_i) begin
					// stop at the failing sector and report it with the remaining count
					err_d[amw_pkg::ERR_IDN] = 1'b1;
					errb_d  = 1'b1;
					bsy_d   = 1'b0;
					int_set = 1'b1;
					state_d = S_IDLE;
					if (ext_q) begin
						cnt_d  = rem_q[15:0];
						low_d  = ext_lane(addr_q, 2'h0);
						mid_d  = ext_lane(addr_q, 2'h1);
						high_d = ext_lane(addr_q, 2'h2);
					end else begin
						// 28-bit form: only current bytes and the head field change
						cnt_d[7:0]  = rem_q[7:0];
						low_d[7:0]  = addr_q[7:0];
						mid_d[7:0]  = addr_q[15:8];
						high_d[7:0] = addr_q[23:16];
						dev_d[3:0]  = addr_q[27:24];
					end
				end else if (media_done_i) begin
					// sector recorded: one fewer left, one more in this block
					rem_d = rem_q - 17'h00001;
					blk_d = blk_q + 8'h01;
					bsy_d = 1'b0;
					if (rem_q == 17'h00001) begin
						// finished: zero left, address of the last sector recorded
						int_set = 1'b1;
						state_d = S_IDLE;
						if (ext_q) begin
							cnt_d  = 16'h0000;
							low_d  = ext_lane(addr_q, 2'h0);
							mid_d  = ext_lane(addr_q, 2'h1);
							high_d = ext_lane(addr_q, 2'h2);
						end else begin
							cnt_d[7:0]  = 8'h00;
							low_d[7:0]  = addr_q[7:0];
							mid_d[7:0]  = addr_q[15:8];
							high_d[7:0] = addr_q[23:16];
							dev_d[3:0]  = addr_q[27:24];
						end
					end else begin
						addr_d  = next_addr(addr_q, chs_q);
						drq_d   = 1'b1;
						state_d = S_XFER;
						// interrupt only at block boundaries, never between sectors of a block
						if (blk_q + 8'h01 == block_size_i) begin
							blk_d   = 8'h00;
							int_set = 1'b1;
						end
					end
				end
			end
			default: state_d = S_IDLE;
		endcase
		// a new event wins over a clear in the same cycle
		intrq_d = int_set || (intrq_q && !int_clr);
	end

	// register stage only; async reset loads the idle task-file values
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= S_IDLE;
			cnt_q   <= amw_pkg::CNT_RESET;
			low_q   <= amw_pkg::LOW_RESET;
			mid_q   <= amw_pkg::ADDR_RESET;
			high_q  <= amw_pkg::ADDR_RESET;
			dev_q   <= amw_pkg::DEV_RESET;
			err_q   <= 8'h00;
			bsy_q   <= 1'b0;
			drq_q   <= 1'b0;
			errb_q  <= 1'b0;
			intrq_q <= 1'b0;
			ext_q   <= 1'b0;
			chs_q   <= 1'b0;
			rem_q   <= 17'h00000;
			blk_q   <= 8'h00;
			addr_q  <= 48'h000000000000;
			rdata_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			low_q   <= low_d;
			mid_q   <= mid_d;
			high_q  <= high_d;
			dev_q   <= dev_d;
			err_q   <= err_d;
			bsy_q   <= bsy_d;
			drq_q   <= drq_d;
			errb_q  <= errb_d;
			intrq_q <= intrq_d;
			ext_q   <= ext_d;
			chs_q   <= chs_d;
			rem_q   <= rem_d;
			blk_q   <= blk_d;
			addr_q  <= addr_d;
			rdata_q <= rdata_d;
		end
	end

	// staged sector goes out with its address for recording
	amw_sector_buffer i_amw_sector_buffer (
		.clk_i         (clk_i),
		.reset_n_i     (reset_n_i),
		.push_i        (push),
		.word_i        (tf_i.wdata),
		.lba_i         (addr_q),
		.full_o        (buf_full),
		.media_o       (media_o),
		.media_valid_o (media_valid_o),
		.media_ready_i (media_ready_i)
	);

	// both host-visible outputs come straight from flops, so no glitches reach the bus
	assign rdata_o = rdata_q;
	assign intrq_o = intrq_q;
endmodule

// >>> verification/amw_chk.sv
`timescale 1ns/10ps
// port-level checks of the block-mode write device
module amw_chk (
	input  wire logic                 clk_i,         // clock
	input  wire logic                 reset_n_i,     // reset, active low
	input  amw_pkg::amw_tf_req_t      tf_i,          // host access
	input  wire logic [15:0]          rdata_o,       // read data
	input  wire logic                 intrq_o,       // interrupt
	input  amw_pkg::amw_media_word_t  media_o,       // media word
	input  wire logic                 media_valid_o, // media valid
	input  wire logic                 media_ready_i, // media ready
	input  wire logic                 media_done_i,  // sector recorded
	input  wire logic                 media_fail_i   // sector failed
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	logic [7:0] wcnt_q;

	// words taken this sector; wraps at 256, so last must fall on 255
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			wcnt_q <= 8'h00;
		else if (media_valid_o && media_ready_i)
			wcnt_q <= wcnt_q + 8'h01;
	end

	property p_hold; media_valid_o && !media_ready_i |=> media_valid_o && $stable(media_o); endproperty
	a_hold: assert property (p_hold) else $error("media word changed before taken");
	property p_last; media_valid_o && media_ready_i |-> media_o.last == (wcnt_q == 8'hff); endproperty
	a_last: assert property (p_last) else $error("sector length wrong");
	property p_next; media_valid_o && media_ready_i && !media_o.last |=> media_valid_o; endproperty
	a_next: assert property (p_next) else $error("drain stalled");
	property p_end; media_valid_o && media_ready_i && media_o.last |=> !media_valid_o [*2]; endproperty
	a_end: assert property (p_end) else $error("drain ran past sector");
	property p_lba; media_valid_o && $past(media_valid_o) |-> $stable(media_o.lba); endproperty
	a_lba: assert property (p_lba) else $error("address moved in sector");
	property p_irq; $rose(intrq_o) |-> !$past(media_valid_o); endproperty
	a_irq: assert property (p_irq) else $error("interrupt during drain");
	property p_clr;
		tf_i.rd && tf_i.sel == amw_pkg::TF_CMD && !media_done_i && !media_fail_i && !$past(media_done_i)
			&& !$past(media_fail_i) |=> !intrq_o;
	endproperty
	a_clr: assert property (p_clr) else $error("status read kept interrupt");
	property p_rd0; tf_i.rd && tf_i.sel == amw_pkg::TF_DATA |=> rdata_o == 16'h0000; endproperty
	a_rd0: assert property (p_rd0) else $error("data port read nonzero");
	property p_rdhold; !tf_i.rd |=> $stable(rdata_o); endproperty
	a_rdhold: assert property (p_rdhold) else $error("read data changed");
	c_irq: cover property ($rose(intrq_o));
	c_last: cover property (media_valid_o && media_ready_i && media_o.last);
	c_fail: cover property (media_fail_i);
endmodule
bind amw_write_multiple amw_chk i_amw_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .tf_i(tf_i),
	.rdata_o(rdata_o), .intrq_o(intrq_o), .media_o(media_o), .media_valid_o(media_valid_o),
	.media_ready_i(media_ready_i), .media_done_i(media_done_i), .media_fail_i(media_fail_i));

// >>> verification/amw_media_model.sv
`timescale 1ns/10ps
// recording side: takes drained words, reports each sector some cycles later
module amw_media_model (
	input  wire logic clk_i,     // clock
	input  wire logic reset_n_i, // reset, active low
	input  wire logic valid_i,   // word offered
	input  wire logic last_i,    // last word of sector
	input  wire logic slow_i,    // stall every other cycle
	input  wire logic fail_i,    // fail this sector
	output logic      ready_o,   // word taken
	output logic      done_o,    // sector recorded, pulse
	output logic      fail_o     // sector failed, pulse
);
	logic       tog_q;
	logic [2:0] cnt_q;

	// slow mode gives back-pressure so the drain must hold its word
	assign ready_o = valid_i && (!slow_i || tog_q);

	// recording takes a few cycles after the last word
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tog_q <= 1'b0;
			cnt_q <= 3'h0;
			done_o <= 1'b0;
			fail_o <= 1'b0;
		end else begin
			tog_q <= !tog_q;
			done_o <= 1'b0;
			fail_o <= 1'b0;
			if (ready_o && last_i)
				cnt_q <= 3'h4;
			else if (cnt_q != 3'h0)
				cnt_q <= cnt_q - 3'h1;
			if (cnt_q == 3'h1) begin
				done_o <= !fail_i;
				fail_o <= fail_i;
			end
		end
	end
endmodule

// >>> verification/tb_ata_multi_sector_write.sv
`timescale 1ns/10ps
module tb_ata_multi_sector_write;
	logic                     clk_i = 1'b0;
	logic                     reset_n_i = 1'b0;
	logic                     hob_i = 1'b0;
	logic                     slow = 1'b0;
	logic                     fail_req = 1'b0;
	logic [7:0]               block_size_i = 8'h01;
	amw_pkg::amw_tf_req_t     tf_i = '0;
	logic [15:0]              rdata_o;
	logic [15:0]              v;
	logic                     intrq_o, media_valid_o, ready, done, fail;
	amw_pkg::amw_media_word_t media_o;
	int                       err_total = 0;
	int                       check_count = 0;

	always #5 clk_i = ~clk_i;

	amw_write_multiple i_amw_write_multiple (.clk_i(clk_i), .reset_n_i(reset_n_i), .tf_i(tf_i),
		.rdata_o(rdata_o), .hob_i(hob_i), .block_size_i(block_size_i), .intrq_o(intrq_o), .media_o(media_o),
		.media_valid_o(media_valid_o), .media_ready_i(ready), .media_done_i(done), .media_fail_i(fail));
	amw_media_model i_amw_media_model (.clk_i(clk_i), .reset_n_i(reset_n_i), .valid_i(media_valid_o),
		.last_i(media_o.last), .slow_i(slow), .fail_i(fail_req), .ready_o(ready), .done_o(done), .fail_o(fail));

	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize;
		$display("mismatches %0d, checks %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// one-cycle strobes, launched at the falling edge
	task automatic tf_write(input logic [2:0] s, input logic [15:0] d);
		@(negedge clk_i);
		tf_i <= '{1'b1, 1'b0, s, d};
		@(negedge clk_i);
		tf_i <= '0;
	endtask

	task automatic expect_reg(input logic [2:0] s, input logic [15:0] e);
		@(negedge clk_i);
		tf_i <= '{1'b0, 1'b1, s, 16'h0000};
		@(negedge clk_i);
		tf_i <= '0;
		v = rdata_o;
		check(v, e);
	endtask

	// bounded waits; running out ends the run as a failure
	task automatic wait_media(input logic want_end);
		for (int i = 0; i < 2000; i++) begin
			if (want_end ? (done || fail) : media_valid_o)
				return;
			@(negedge clk_i);
		end
		err_total++;
		summarize();
	endtask

	// polls status for data request, then streams one sector back to back
	task automatic sector(input logic [47:0] lba, input logic bad);
		for (int i = 0; i <= 300; i++) begin
			if (i == 300) begin
				err_total++;
				summarize();
			end
			@(negedge clk_i);
			tf_i <= '{1'b0, 1'b1, amw_pkg::TF_CMD, 16'h0000};
			@(negedge clk_i);
			tf_i <= '0;
			if (rdata_o[amw_pkg::ST_DRQ] === 1'b1)
				break;
		end
		fail_req = bad;
		for (int i = 0; i < 256; i++) begin
			@(negedge clk_i);
			tf_i <= '{1'b1, 1'b0, amw_pkg::TF_DATA, {8'ha5, i[7:0]}};
		end
		@(negedge clk_i);
		tf_i <= '0;
		wait_media(1'b0);
		check(media_o.lba, lba);
		check(media_o.data, 48'h00a500);
		wait_media(1'b1);
		repeat (2) @(negedge clk_i);
	endtask

	task automatic t_reset;
		logic [15:0] tbl [7] = '{16'h0000, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h00a0, 16'h0050};
		for (int s = 1; s < 8; s++)
			expect_reg(3'(s), tbl[s-1]);
	endtask

	// two sectors in one block: only one interrupt, at the end
	task automatic t_lba_block;
		block_size_i = 8'h02;
		tf_write(amw_pkg::TF_CNT, 16'h0002);
		tf_write(amw_pkg::TF_LOW, 16'h0010);
		tf_write(amw_pkg::TF_MID, 16'h0020);
		tf_write(amw_pkg::TF_HIGH, 16'h0030);
		tf_write(amw_pkg::TF_DEV, 16'h00e5);
		tf_write(amw_pkg::TF_CMD, {8'h00, amw_pkg::CMD_WR_MULT});
		sector(48'h5302010, 1'b0);
		check(intrq_o, 1'b0);
		sector(48'h5302011, 1'b0);
		check(intrq_o, 1'b1);
		expect_reg(amw_pkg::TF_CMD, 16'h0050);
		expect_reg(amw_pkg::TF_CNT, 16'h0000);
		expect_reg(amw_pkg::TF_LOW, 16'h0011);
		expect_reg(amw_pkg::TF_DEV, 16'h00e5);
	endtask

	// chs mode with a stalling media side; sector 63 wraps to the next head
	task automatic t_chs;
		block_size_i = 8'h01;
		slow = 1'b1;
		tf_write(amw_pkg::TF_CNT, 16'h0002);
		tf_write(amw_pkg::TF_LOW, 16'h003f);
		tf_write(amw_pkg::TF_MID, 16'h0001);
		tf_write(amw_pkg::TF_HIGH, 16'h0000);
		tf_write(amw_pkg::TF_DEV, 16'h00a3);
		tf_write(amw_pkg::TF_CMD, {8'h00, amw_pkg::CMD_WR_MULT});
		sector(48'h300013f, 1'b0);
		sector(48'h4000101, 1'b0);
		slow = 1'b0;
		expect_reg(amw_pkg::TF_LOW, 16'h0001);
		expect_reg(amw_pkg::TF_MID, 16'h0001);
		expect_reg(amw_pkg::TF_DEV, 16'h00a4);
	endtask

	// extended write whose only sector fails: stop there and report it
	task automatic t_ext_fail;
		tf_write(amw_pkg::TF_CNT, 16'h0000);
		tf_write(amw_pkg::TF_CNT, 16'h0001);
		tf_write(amw_pkg::TF_LOW, 16'h0044);
		tf_write(amw_pkg::TF_LOW, 16'h0011);
		tf_write(amw_pkg::TF_MID, 16'h0055);
		tf_write(amw_pkg::TF_MID, 16'h0022);
		tf_write(amw_pkg::TF_HIGH, 16'h0066);
		tf_write(amw_pkg::TF_HIGH, 16'h0033);
		tf_write(amw_pkg::TF_DEV, 16'h00e0);
		tf_write(amw_pkg::TF_CMD, {8'h00, amw_pkg::CMD_WR_MULT_EXT});
		sector(48'h665544332211, 1'b1);
		fail_req = 1'b0;
		check(intrq_o, 1'b1);
		expect_reg(amw_pkg::TF_CMD, 16'h0051);
		expect_reg(amw_pkg::TF_ERR, 16'h0010);
		expect_reg(amw_pkg::TF_CNT, 16'h0001);
		expect_reg(amw_pkg::TF_LOW, 16'h0011);
		hob_i = 1'b1;
		expect_reg(amw_pkg::TF_LOW, 16'h0044);
		expect_reg(amw_pkg::TF_HIGH, 16'h0066);
		hob_i = 1'b0;
	endtask

	// missing block size and an unknown code both abort
	task automatic t_abort;
		for (int k = 0; k < 2; k++) begin
			block_size_i = k ? 8'h01 : 8'h00;
			tf_write(amw_pkg::TF_CMD, k ? 16'h0020 : 16'h00c5);
			@(negedge clk_i);
			check(intrq_o, 1'b1);
			expect_reg(amw_pkg::TF_ERR, 16'h0004);
			expect_reg(amw_pkg::TF_CMD, 16'h0051);
		end
	endtask

	// reset in the middle of a sector: everything returns to idle values
	task automatic t_midreset;
		block_size_i = 8'h01;
		tf_write(amw_pkg::TF_CNT, 16'h0003);
		tf_write(amw_pkg::TF_DEV, 16'h00e0);
		tf_write(amw_pkg::TF_CMD, {8'h00, amw_pkg::CMD_WR_MULT});
		expect_reg(amw_pkg::TF_CMD, 16'h0058);
		for (int i = 0; i < 10; i++) begin
			@(negedge clk_i);
			tf_i <= '{1'b1, 1'b0, amw_pkg::TF_DATA, 16'h1234};
		end
		@(negedge clk_i);
		tf_i <= '0;
		reset_n_i = 1'b0;
		repeat (2) @(negedge clk_i);
		reset_n_i = 1'b1;
		check(intrq_o, 1'b0);
		check(media_valid_o, 1'b0);
		expect_reg(amw_pkg::TF_CMD, 16'h0050);
		expect_reg(amw_pkg::TF_CNT, 16'h0001);
	endtask

	initial begin
		repeat (12) @(negedge clk_i);
		reset_n_i = 1'b1;
		t_reset();
		t_lba_block();
		t_chs();
		t_ext_fail();
		t_abort();
		t_midreset();
		summarize();
	end
endmodule
